// ===== timer_unit_pkg.sv
// constants and types of the programmable timer unit
// Function
// - timer B width field picks pulse low time
// - source select picks the timer tick
// - function 01 countdown, 10 watchdog
// - watchdog flag set on tick at count 1
// - watchdog irq only when its enable set
// - watchdog irq pulsed or level per mode bit
// - nonzero write clears flag, restarts watchdog
// - zero write clears flag, halts watchdog
// - control read clears watchdog flag
// - countdown at 1: flag, irq, reload
// - countdown flag cleared only by host
// - value read returns live count
// - count write takes effect at once
// - zero count halts countdown
// - first period uncertain per source
// - countdown irq pulsed or level, maskable
// - mode bit 0 level, 1 pulse
package timer_unit_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL_2 = 8'h01;
    localparam logic [7:0] OFS_TMR_CTRL  = 8'h0F;
    localparam logic [7:0] OFS_A_SOURCE  = 8'h10;
    localparam logic [7:0] OFS_A_VALUE   = 8'h11;
    localparam logic [7:0] OFS_B_CONFIG  = 8'h12;
    localparam logic [7:0] OFS_B_VALUE   = 8'h13;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_WDOG_FLAG  = 7; // watchdog_expired_flag
    localparam int BIT_CD_FLAG    = 6; // countdown_a_flag
    localparam int BIT_WDOG_IE    = 2; // watchdog_irq_enable
    localparam int BIT_CD_IE      = 1; // countdown_a_irq_enable
    localparam int BIT_PULSE_SEL  = 7; // timer_a_irq_pulse_select
    localparam int FUNC_LSB       = 1; // timer_a_function_select
    localparam int PW_LSB         = 4; // timer_b_pulse_width

    // ----------------------------------------------------------------
    // reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] RST_SOURCE = 3'h7;
    localparam logic [2:0] RST_PW     = 3'h0;
    localparam logic [7:0] RST_VALUE  = 8'h00;
    localparam logic [2:0] SRC_4K     = 3'h0;
    localparam logic [2:0] SRC_64     = 3'h1;
    localparam logic [2:0] SRC_1HZ    = 3'h2;
    localparam logic [2:0] SRC_MIN    = 3'h3;

    // timer A function codes
    typedef enum logic [1:0] {
        FUNC_OFF       = 2'h0,
        FUNC_COUNTDOWN = 2'h1,
        FUNC_WATCHDOG  = 2'h2,
        FUNC_SPARE     = 2'h3
    } func_t;

    // ----------------------------------------------------------------
    // timing: pulse widths in us, counted in 8192 Hz ticks
    // ----------------------------------------------------------------
    localparam int SUB_HZ      = 8192;
    localparam int PW_4K_1_US  = 122;
    localparam int PW_4K_N_US  = 244;
    localparam int PW_64_1_US  = 7812;
    localparam int PW_SLOW_US  = 15625;
    localparam int PW_4K_1  = (PW_4K_1_US * SUB_HZ + 500000) / 1000000;
    localparam int PW_4K_N  = (PW_4K_N_US * SUB_HZ + 500000) / 1000000;
    localparam int PW_64_1  = (PW_64_1_US * SUB_HZ + 500000) / 1000000;
    localparam int PW_SLOW  = (PW_SLOW_US * SUB_HZ + 500000) / 1000000;
    localparam int B_PW_US [8] = '{46875, 62500, 78125, 93750,
                                   125000, 156250, 187500, 218750};
    localparam int SEC_PER_MIN = 60;
    localparam int MIN_PER_HR  = 60;

    // register access from the serial interface engine
    typedef struct packed {
        logic       wr;    // write strobe
        logic       rd;    // read strobe
        logic [7:0] addr;  // register offset
        logic [7:0] wdata; // write data
    } reg_req_t;

endpackage : timer_unit_pkg

// ===== timer_unit.sv
// timer A watchdog/countdown engine, timer B configuration
module timer_unit
(
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   ce,
    input  wire timer_unit_pkg::reg_req_t reg_req,
    input  wire logic                   osc_in,
    output logic [7:0]                  reg_rdata,
    output logic                        irq_pin_primary_out,
    output logic                        irq_pin_primary_oe,
    output logic                        timer_b_tick,
    output logic [10:0]                 timer_b_pulse_ticks
);

    // ----------------------------------------------------------------
    // crystal synchroniser and prescaler
    // ----------------------------------------------------------------
    logic [1:0]  osc_sync;     // two-flop synchroniser
    logic        osc_prev;     // last synchronised level
    logic [14:0] pre;          // crystal prescaler
    logic [5:0]  sec_cnt;      // seconds within minute
    logic [5:0]  min_cnt;      // minutes within hour
    logic [14:0] next_pre;
    logic [5:0]  next_sec_cnt;
    logic [5:0]  next_min_cnt;
    logic        osc_rise;
    logic        tick_8k;
    logic        tick_4k;
    logic        tick_64;
    logic        tick_1;
    logic        tick_min;
    logic        tick_hr;

    // last second of a minute and last minute of an hour
    localparam int SEC_PER_MIN_M1 = timer_unit_pkg::SEC_PER_MIN - 1;
    localparam int MIN_PER_HR_M1  = timer_unit_pkg::MIN_PER_HR - 1;

    // crystal pin crosses into mclk before use
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            osc_sync <= 2'h0;
            osc_prev <= 1'b0;
        end
        else if (ce)
        begin
            osc_sync <= {osc_sync[0], osc_in};
            osc_prev <= osc_sync[1];
        end
    end

    // tick strobes from the prescaler state
    always_comb
    begin
        osc_rise = osc_sync[1] & ~osc_prev;
        tick_8k  = osc_rise & (&pre[1:0]);
        tick_4k  = osc_rise & (&pre[2:0]);
        tick_64  = osc_rise & (&pre[8:0]);
        tick_1   = osc_rise & (&pre);
        tick_min = tick_1 & (sec_cnt == 6'(SEC_PER_MIN_M1));
        tick_hr  = tick_min & (min_cnt == 6'(MIN_PER_HR_M1));
        next_pre     = osc_rise ? pre + 15'h0001 : pre;
        next_sec_cnt = sec_cnt;
        next_min_cnt = min_cnt;
        if (tick_1)
            next_sec_cnt = tick_min ? 6'h00 : sec_cnt + 6'h01;
        if (tick_min)
            next_min_cnt = tick_hr ? 6'h00 : min_cnt + 6'h01;
    end

    // prescaler registers
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pre     <= 15'h0000;
            sec_cnt <= 6'h00;
            min_cnt <= 6'h00;
        end
        else if (ce)
        begin
            pre     <= next_pre;
            sec_cnt <= next_sec_cnt;
            min_cnt <= next_min_cnt;
        end
    end

    // pick the tick of one source code
    function automatic logic src_tick(input logic [2:0] sel, input logic t4k,
                                      input logic t64, input logic t1,
                                      input logic tm, input logic th);
        unique case (sel)
            timer_unit_pkg::SRC_4K:  src_tick = t4k;
            timer_unit_pkg::SRC_64:  src_tick = t64;
            timer_unit_pkg::SRC_1HZ: src_tick = t1;
            timer_unit_pkg::SRC_MIN: src_tick = tm;
            default:                 src_tick = th;
        endcase
    endfunction : src_tick

    // ----------------------------------------------------------------
    // registers and timer A
    // ----------------------------------------------------------------
    timer_unit_pkg::func_t func, next_func; // timer_a_function_select
    logic        pulse_sel;    // timer_a_irq_pulse_select
    logic [2:0]  a_src;        // timer_a_source_select
    logic [7:0]  a_value;      // programmed timer A value
    logic [2:0]  b_pw;         // timer_b_pulse_width
    logic [2:0]  b_src;        // timer_b_source_select
    logic [7:0]  b_value;      // timer B value
    logic        wd_ie;        // watchdog_irq_enable
    logic        cd_ie;        // countdown_a_irq_enable
    logic        wd_flag;      // watchdog_expired_flag
    logic        cd_flag;      // countdown_a_flag
    logic [7:0]  count;        // live timer A count
    logic        first;        // first tick of a period pending
    logic [7:0]  pulse_cnt;    // remaining pulse low time
    logic        next_pulse_sel;
    logic [2:0]  next_a_src;
    logic [7:0]  next_a_value;
    logic [2:0]  next_b_pw;
    logic [2:0]  next_b_src;
    logic [7:0]  next_b_value;
    logic        next_wd_ie;
    logic        next_cd_ie;
    logic        next_wd_flag;
    logic        next_cd_flag;
    logic [7:0]  next_count;
    logic        next_first;
    logic [7:0]  next_pulse_cnt;
    logic [7:0]  next_rdata;
    logic        next_irq_oe;
    logic        next_b_tick;
    logic [10:0] next_b_pulse;
    logic        wr_ctl2;      // host write to control register
    logic        rd_ctl2;      // host read of control register
    logic        wr_aval;      // host write of timer A value
    logic        a_tick;       // decrement strobe for timer A
    logic        slow_src;     // source slower than 64 Hz
    logic        running;      // timer A active with nonzero count
    logic        cd_event;     // countdown period end
    logic        wd_event;     // watchdog expiry
    logic [7:0]  pulse_len;    // pulse length for this event
    logic        level;        // enabled flag sources

    // next state of registers, counter, flags and output
    always_comb
    begin
        wr_ctl2  = reg_req.wr & (reg_req.addr == timer_unit_pkg::OFS_CONTROL_2);
        rd_ctl2  = reg_req.rd & (reg_req.addr == timer_unit_pkg::OFS_CONTROL_2);
        wr_aval  = reg_req.wr & (reg_req.addr == timer_unit_pkg::OFS_A_VALUE);
        slow_src = (a_src != timer_unit_pkg::SRC_4K) && (a_src != timer_unit_pkg::SRC_64);
        // slow sources start their first period on the 64 Hz grid
        a_tick   = (first && slow_src) ? tick_64
                 : src_tick(a_src, tick_4k, tick_64, tick_1, tick_min, tick_hr);
        running  = ((func == timer_unit_pkg::FUNC_COUNTDOWN)
                 || (func == timer_unit_pkg::FUNC_WATCHDOG))
                 && (count != 8'h00);
        cd_event = a_tick && running && (count == 8'h01)
                 && (func == timer_unit_pkg::FUNC_COUNTDOWN);
        wd_event = a_tick && running && (count == 8'h01)
                 && (func == timer_unit_pkg::FUNC_WATCHDOG);
        // pulse width follows source and loaded value
        if (a_src == timer_unit_pkg::SRC_4K)
            pulse_len = (a_value == 8'h01) ? 8'(timer_unit_pkg::PW_4K_1)
                                           : 8'(timer_unit_pkg::PW_4K_N);
        else if (a_src == timer_unit_pkg::SRC_64 && a_value == 8'h01)
            pulse_len = 8'(timer_unit_pkg::PW_64_1);
        else
            pulse_len = 8'(timer_unit_pkg::PW_SLOW);
        // defaults hold every register except the flags, the pulse timer, the irq pin output enable and the timer B outputs
        next_func      = func;
        next_pulse_sel = pulse_sel;
        next_a_src     = a_src;
        next_a_value   = a_value;
        next_b_pw      = b_pw;
        next_b_src     = b_src;
        next_b_value   = b_value;
        next_wd_ie     = wd_ie;
        next_cd_ie     = cd_ie;
        next_count     = count;
        next_first     = first;
        next_rdata     = reg_rdata;
        // host writes
        if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                timer_unit_pkg::OFS_CONTROL_2:
                begin
                    next_wd_ie = reg_req.wdata[timer_unit_pkg::BIT_WDOG_IE];
                    next_cd_ie = reg_req.wdata[timer_unit_pkg::BIT_CD_IE];
                end
                timer_unit_pkg::OFS_TMR_CTRL:
                begin
                    next_pulse_sel = reg_req.wdata[timer_unit_pkg::BIT_PULSE_SEL];
                    next_func  = timer_unit_pkg::func_t'(
                        reg_req.wdata[timer_unit_pkg::FUNC_LSB +: 2]);
                    next_first = 1'b1;
                end
                timer_unit_pkg::OFS_A_SOURCE: next_a_src = reg_req.wdata[2:0];
                timer_unit_pkg::OFS_A_VALUE:
                begin
                    next_a_value = reg_req.wdata;
                    next_first   = 1'b1;
                end
                timer_unit_pkg::OFS_B_CONFIG:
                begin
                    next_b_pw  = reg_req.wdata[timer_unit_pkg::PW_LSB +: 3];
                    next_b_src = reg_req.wdata[2:0];
                end
                timer_unit_pkg::OFS_B_VALUE: next_b_value = reg_req.wdata;
                default: ;
            endcase
        end
        // counter: a write loads at once, else tick steps
        if (wr_aval)
            next_count = reg_req.wdata;
        else if (a_tick && running)
        begin
            next_first = 1'b0;
            if (count == 8'h01)
                next_count = cd_event ? a_value : 8'h00;
            else
                next_count = count - 8'h01;
        end
        // flags: the event wins over any clear
        next_wd_flag = wd_event | (wd_flag & ~rd_ctl2 & ~wr_aval);
        next_cd_flag = cd_event | (cd_flag
                     & ~(wr_ctl2 & ~reg_req.wdata[timer_unit_pkg::BIT_CD_FLAG]));
        // pulse timer restarts on each enabled event
        if ((cd_event && next_cd_ie) || (wd_event && next_wd_ie))
            next_pulse_cnt = pulse_len;
        else if (tick_8k && pulse_cnt != 8'h00)
            next_pulse_cnt = pulse_cnt - 8'h01;
        else
            next_pulse_cnt = pulse_cnt;
        // enabled sources, cut short when a flag is cleared
        level = (next_wd_flag & next_wd_ie) | (next_cd_flag & next_cd_ie);
        next_irq_oe = next_pulse_sel ? (level & (next_pulse_cnt != 8'h00))
                                     : level;
        // read data; reading shows live state
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                timer_unit_pkg::OFS_CONTROL_2:
                    next_rdata = {wd_flag, cd_flag, 3'h0, wd_ie, cd_ie, 1'b0};
                timer_unit_pkg::OFS_TMR_CTRL:
                    next_rdata = {pulse_sel, 4'h0, func, 1'b0};
                timer_unit_pkg::OFS_A_SOURCE: next_rdata = {5'h00, a_src};
                timer_unit_pkg::OFS_A_VALUE:  next_rdata = count;
                timer_unit_pkg::OFS_B_CONFIG:
                    next_rdata = {1'b0, b_pw, 1'b0, b_src};
                timer_unit_pkg::OFS_B_VALUE:  next_rdata = b_value;
                default:                      next_rdata = 8'h00;
            endcase
        end
        // timer B tick and pulse length for its engine
        next_b_tick  = src_tick(b_src, tick_4k, tick_64, tick_1, tick_min, tick_hr);
        next_b_pulse = 11'((timer_unit_pkg::B_PW_US[b_pw] * timer_unit_pkg::SUB_HZ
                          + 500000) / 1000000);
    end

    // register every next value; ce freezes all
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            func                <= timer_unit_pkg::FUNC_OFF;
            pulse_sel           <= 1'b0;
            a_src               <= timer_unit_pkg::RST_SOURCE;
            a_value             <= timer_unit_pkg::RST_VALUE;
            b_pw                <= timer_unit_pkg::RST_PW;
            b_src               <= timer_unit_pkg::RST_SOURCE;
            b_value             <= timer_unit_pkg::RST_VALUE;
            wd_ie               <= 1'b0;
            cd_ie               <= 1'b0;
            wd_flag             <= 1'b0;
            cd_flag             <= 1'b0;
            count               <= timer_unit_pkg::RST_VALUE;
            first               <= 1'b1;
            pulse_cnt           <= 8'h00;
            reg_rdata           <= 8'h00;
            irq_pin_primary_oe  <= 1'b0;
            irq_pin_primary_out <= 1'b0;
            timer_b_tick        <= 1'b0;
            timer_b_pulse_ticks <= 11'h000;
        end
        else if (ce)
        begin
            func                <= next_func;
            pulse_sel           <= next_pulse_sel;
            a_src               <= next_a_src;
            a_value             <= next_a_value;
            b_pw                <= next_b_pw;
            b_src               <= next_b_src;
            b_value             <= next_b_value;
            wd_ie               <= next_wd_ie;
            cd_ie               <= next_cd_ie;
            wd_flag             <= next_wd_flag;
            cd_flag             <= next_cd_flag;
            count               <= next_count;
            first               <= next_first;
            pulse_cnt           <= next_pulse_cnt;
            reg_rdata           <= next_rdata;
            irq_pin_primary_oe  <= next_irq_oe;
            irq_pin_primary_out <= 1'b0;
            timer_b_tick        <= next_b_tick;
            timer_b_pulse_ticks <= next_b_pulse;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_wd_expiry: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && wd_event && !wr_aval) |=> (wd_flag && count == 8'h00))
        else $error("watchdog expiry did not set flag");
    a_wd_irq_gate: assert property (@(posedge mclk) disable iff (!rstn)
        (irq_pin_primary_oe && !cd_ie) |-> (wd_ie && wd_flag))
        else $error("irq active without enabled watchdog source");
    a_cd_reload: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && cd_event && !wr_aval) |=> (cd_flag && count == $past(a_value)))
        else $error("countdown did not reload");
    a_ctl_read_clear: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && rd_ctl2 && !wd_event) |=> !wd_flag)
        else $error("control read left watchdog flag set");
    a_cd_flag_sticky: assert property (@(posedge mclk) disable iff (!rstn)
        (cd_flag && !(ce && wr_ctl2)) |=> cd_flag)
        else $error("countdown flag lost without host clear");
    a_live_read: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && reg_req.rd && reg_req.addr == timer_unit_pkg::OFS_A_VALUE)
        |=> reg_rdata == $past(count))
        else $error("value read did not return live count");
    a_zero_halt: assert property (@(posedge mclk) disable iff (!rstn)
        (count == 8'h00 && !(ce && wr_aval)) |=> count == 8'h00)
        else $error("zero count did not halt");
    a_count_write: assert property (@(posedge mclk) disable iff (!rstn)
        (ce && wr_aval) |=> count == $past(reg_req.wdata))
        else $error("count write not taken at once");
    a_level_mode: assert property (@(posedge mclk) disable iff (!rstn)
        (!pulse_sel && cd_flag && cd_ie) |-> irq_pin_primary_oe)
        else $error("level mode irq not active");
    a_pulse_end: assert property (@(posedge mclk) disable iff (!rstn)
        (pulse_sel && pulse_cnt == 8'h00) |-> !irq_pin_primary_oe)
        else $error("pulse mode irq outlived its pulse");

endmodule : timer_unit

// ===== host_model.sv
// host side model: register requests and the crystal clock
module host_model
(
    input  wire logic                     mclk,
    input  wire logic [7:0]               reg_rdata,
    output timer_unit_pkg::reg_req_t      reg_req,
    output logic                          osc_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] ph; // crystal phase count

    initial
    begin
        reg_req = '0;
        osc_in  = 1'b0;
        ph      = 2'h0;
    end

    // crystal toggles every four mclk, well above the three-cycle minimum
    always @(posedge mclk)
    begin
        ph <= ph + 2'h1;
        if (ph == 2'h3) osc_in <= ~osc_in;
    end

    // one-cycle write strobe, held until the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask : wr

    // one-cycle read strobe; data is settled one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask : rd

    // live count is read until two reads in a row agree, six reads at most
    task automatic rd2(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] p;
        rd(a, p);
        rd(a, d);
        repeat (4) if (d !== p) begin p = d; rd(a, d); end
    endtask : rd2
endmodule : host_model

// ===== tb_top.sv
// self-checking bench of the timer unit
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     mclk;   // 200 MHz clock
    logic                     rstn;   // sync reset, active low
    logic                     ce;     // clock enable
    timer_unit_pkg::reg_req_t reg_req;
    logic                     osc_in; // crystal level
    logic [7:0]               rdata;  // read data
    logic                     oe;     // irq pin driven low
    logic [10:0]              pw;     // timer B pulse ticks
    logic                     od;     // irq pin data level
    logic                     btk;    // timer B tick
    logic [7:0]               d;      // last read byte
    logic [7:0]               s;      // random state
    int                       n_fail;
    int                       n_tests;
    int                       cyc;    // run length
    int                       n;      // measured wait

    timer_unit u_dut (.mclk(mclk), .rstn(rstn), .ce(ce), .reg_req(reg_req),
        .osc_in(osc_in), .reg_rdata(rdata), .irq_pin_primary_out(od),
        .irq_pin_primary_oe(oe), .timer_b_tick(btk), .timer_b_pulse_ticks(pw));
    host_model h (.mclk(mclk), .reg_rdata(rdata), .reg_req(reg_req), .osc_in(osc_in));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // next random byte
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    // pulse low time in 8192 Hz ticks for a width code
    function automatic logic [10:0] pw_exp(input int c);
        return 11'((c < 4) ? 384 + 128 * c : 1024 + 256 * (c - 4));
    endfunction : pw_exp

    task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] e);
        n_tests++;
        if (seen !== e) begin n_fail++; $display("[FAIL] %s exp %h seen %h", nm, e, seen); end
    endtask : chk

    // read a register and compare the masked byte
    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        h.rd(a, d);
        chk($sformatf("reg %h", a), 11'(d & m), 11'(e));
    endtask : rc

    // wait up to lim cycles for the pin to reach lvl; e says if it should
    task automatic wt(input logic lvl, input int lim, input logic e);
        n = 0;
        // let the edge that took the last request settle first
        #1;
        while (oe !== lvl && n < lim)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("irq", 11'(oe === lvl), 11'(e));
    endtask : wt

    task automatic results();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin n_fail++; results(); end
    end

    initial
    begin
        rstn = 1'b0; ce = 1'b1; s = 8'h07; cyc = 0; n_fail = 0; n_tests = 0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        // reset values
        rc(8'h0F, 8'hFF, 8'h00);
        rc(8'h10, 8'h07, 8'h07);
        rc(8'h12, 8'h77, 8'h07);
        rc(8'h55, 8'hFF, 8'h00);
        $display("test reset done");
        // every width code with a random source code
        for (int i = 0; i < 8; i++)
        begin
            s = lfsr(s);
            h.wr(8'h12, {1'b0, 3'(i), 1'b0, s[2:0]});
            rc(8'h12, 8'h77, {1'b0, 3'(i), 1'b0, s[2:0]});
            chk("b_width", pw, pw_exp(i));
        end
        // timer B tick spacing at the 4096 Hz source
        h.wr(8'h12, 8'h00);
        wait (btk === 1'b1);
        @(posedge mclk);
        #1;
        n = 1;
        while (btk !== 1'b1 && n < 200)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("b_tick", 11'(n), 11'h040);
        $display("test width done");
        // countdown of 3 at 4096 Hz, level mode
        h.wr(8'h10, 8'h00);
        h.wr(8'h01, 8'h02);
        h.wr(8'h11, 8'h03);
        h.wr(8'h0F, 8'h02);
        wt(1'b1, 400, 1'b1);
        rc(8'h01, 8'h40, 8'h40);
        h.rd2(8'h11, d);
        chk("live", 11'(d inside {[1:3]}), 11'h001);
        h.wr(8'h01, 8'h02);
        wt(1'b0, 6, 1'b1);
        // a low clock enable freezes the countdown
        @(posedge mclk);
        ce <= 1'b0;
        wt(1'b1, 300, 1'b0);
        @(posedge mclk);
        ce <= 1'b1;
        wt(1'b1, 300, 1'b1);
        h.wr(8'h01, 8'h02);
        wt(1'b1, 300, 1'b1);
        chk("period", 11'(n inside {[150:200]}), 11'h001);
        h.wr(8'h01, 8'h00);
        wt(1'b1, 300, 1'b0);
        rc(8'h01, 8'h40, 8'h40);
        $display("test countdown done");
        // pulse mode: pin releases while the flag stays
        h.wr(8'h01, 8'h02);
        h.wr(8'h0F, 8'h82);
        wt(1'b1, 300, 1'b1);
        wt(1'b0, 120, 1'b1);
        rc(8'h01, 8'h40, 8'h40);
        // zero count halts
        h.wr(8'h0F, 8'h02);
        h.wr(8'h11, 8'h00);
        h.wr(8'h01, 8'h02);
        wt(1'b1, 400, 1'b0);
        rc(8'h11, 8'hFF, 8'h00);
        $display("test pulse done");
        // watchdog of a random short count
        h.wr(8'h0F, 8'h00);
        h.wr(8'h01, 8'h04);
        s = lfsr(s);
        h.wr(8'h11, {6'h00, s[1:0] | 2'h1});
        h.wr(8'h0F, 8'h04);
        wt(1'b1, 300, 1'b1);
        rc(8'h11, 8'hFF, 8'h00);
        rc(8'h01, 8'h80, 8'h80);
        wt(1'b0, 4, 1'b1);
        rc(8'h01, 8'h80, 8'h00);
        // masked expiry sets only the flag
        h.wr(8'h01, 8'h00);
        h.wr(8'h11, 8'h02);
        wt(1'b1, 300, 1'b0);
        h.wr(8'h01, 8'h04);
        wt(1'b1, 6, 1'b1);
        h.wr(8'h11, 8'h03);
        wt(1'b0, 4, 1'b1);
        wt(1'b1, 300, 1'b1);
        h.wr(8'h11, 8'h00);
        wt(1'b0, 4, 1'b1);
        wt(1'b1, 400, 1'b0);
        chk("pin_data", 11'(od), 11'h000);
        $display("test watchdog done");
        results();
    end
endmodule : tb_top
